// ---- verilog/ccp_pkg.sv ----
// Shared constants and types of the codec control port.
// Assumes one 200 MHz core clock; link pins arrive unsynchronised.
package ccp_pkg;

  // Core clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Chip address of the four-wire mode and fixed upper bits of the two-wire mode.
  localparam logic [6:0] SPI_CHIP_ADDR = 7'h4F;
  localparam logic [4:0] I2C_ADDR_HI   = 5'h13;

  // Register index of the power control register and its value after reset.
  localparam logic [6:0] PWR_CTRL_IDX = 7'h02;
  localparam logic [7:0] PWR_CTRL_RST = 8'h81;
  localparam int unsigned PDN_BIT     = 0;

  // Pointer byte layout.
  localparam int unsigned PTR_STEP_BIT = 7;

  // Register file geometry.
  localparam int unsigned REG_IDX_W = 7;
  localparam int unsigned REG_DEPTH = 128;

  // Output mute time after reset release, and its length in core cycles.
  localparam longint unsigned MUTE_TIME_MS = 80;
  localparam longint unsigned MUTE_CYCLES  = (MUTE_TIME_MS * 64'd1000000) / CLK_PERIOD_NS;
  localparam int unsigned     MUTE_CNT_W   = 25;

  // Number of interrupt sources.
  localparam int unsigned INT_SRC_N = 8;

  typedef enum logic [1:0] {
    CCP_TRIG_LEVEL,
    CCP_TRIG_RISE,
    CCP_TRIG_FALL
  } ccp_trig_t;

  typedef enum logic [1:0] {
    CCP_INT_LOW_PP,
    CCP_INT_HIGH_PP,
    CCP_INT_LOW_OD
  } ccp_int_pin_t;

endpackage

// ---- verilog/ccp_mem_if.sv ----
// Connection between the port controller and its register memory.
// Assumes both ends sit on the same core clock.
interface ccp_mem_if;
  import ccp_pkg::*;

  logic                 we;
  logic [REG_IDX_W-1:0] waddr;
  logic [7:0]           wdata;
  logic [REG_IDX_W-1:0] raddr;
  logic [7:0]           rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- verilog/ccp_reg_mem.sv ----
// Register memory of the control port, read data registered.
// Assumes a synchronous active-low reset that clears every register except the power control register, which loads PWR_CTRL_RST.
module ccp_reg_mem
  import ccp_pkg::*;
#(
  parameter int unsigned DEPTH = REG_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  ccp_mem_if.mem    mem
);

  logic [7:0] regs_r [DEPTH];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        regs_r[i] <= (i == int'(PWR_CTRL_IDX)) ? PWR_CTRL_RST : 8'h00;
      end
    end else if (mem.we) begin
      regs_r[mem.waddr] <= mem.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mem.rdata <= 8'h00;
    end else begin
      mem.rdata <= regs_r[mem.raddr];
    end
  end

endmodule

// ---- verilog/ccp_top.sv ----
// Codec control port: four-wire and two-wire register access, interrupt pin, power sequencing.
// Assumes link pins are asynchronous to clk_i; interrupt and clock status inputs are on clk_i.
module ccp_top
  import ccp_pkg::*;
#(
  parameter longint unsigned MUTE_LEN = MUTE_CYCLES,
  parameter int unsigned     SRC_N    = INT_SRC_N
) (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Link pins; the serial output pin doubles as the two-wire data line.
  input  wire logic                  addr0_or_select_pin_i,
  input  wire logic                  addr_sel_high_bit_i,
  input  wire logic                  ctrl_bit_clock_i,
  input  wire logic                  ctrl_serial_in_i,
  input  wire logic                  ctrl_serial_out_i,
  output logic                       ctrl_serial_out_o,
  output logic                       ctrl_serial_out_oe_o,
  // Register write notification.
  output logic                       reg_wr_o,
  output logic [REG_IDX_W-1:0]       reg_wr_idx_o,
  output logic [7:0]                 reg_wr_data_o,
  // Mode status.
  output logic                       spi_mode_o,
  // Interrupt configuration, sources and pin.
  input  wire logic [SRC_N-1:0]      int_cond_i,
  input  wire logic [SRC_N-1:0]      int_mask_i,
  input  wire ccp_pkg::ccp_trig_t    int_trig_i [SRC_N],
  input  wire ccp_pkg::ccp_int_pin_t int_pin_mode_i,
  input  wire logic [SRC_N-1:0]      int_clear_i,
  output logic [SRC_N-1:0]           int_status_o,
  output logic                       int_o,
  output logic                       int_oe_o,
  // Power and clock sequencing.
  input  wire logic                  pll_selected_i,
  input  wire logic                  pll_locked_i,
  output logic                       power_down_o,
  output logic                       mute_o,
  output logic                       audio_out_en_o
);
  import ccp_pkg::*;

  typedef enum logic [2:0] {
    CCP_IDLE,
    CCP_ADDR,
    CCP_PTR,
    CCP_WDATA,
    CCP_RDATA,
    CCP_DEV_ACK,
    CCP_HOST_ACK,
    CCP_IGNORE
  } ccp_state_t;

  ccp_mem_if mem_if ();

  ccp_reg_mem #(.DEPTH(REG_DEPTH)) u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .mem     (mem_if.mem)
  );

  // Two-stage synchronisers, then one more stage for edge detection.
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] sync3_r;

  always_ff @(posedge clk_i) begin
    sync1_r <= {addr_sel_high_bit_i, ctrl_serial_out_i, ctrl_serial_in_i, ctrl_bit_clock_i, addr0_or_select_pin_i};
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  wire logic sel_s     = sync2_r[0];
  wire logic sclk_s    = sync2_r[1];
  wire logic din_spi_s = sync2_r[2];
  wire logic sda_s     = sync2_r[3];
  wire logic sclk_rise = sclk_s & ~sync3_r[1];
  wire logic sclk_fall = ~sclk_s & sync3_r[1];
  wire logic sel_fall  = ~sel_s & sync3_r[0];
  wire logic i2c_start = sclk_s & sync3_r[1] & ~sda_s & sync3_r[3];
  wire logic i2c_stop  = sclk_s & sync3_r[1] & sda_s & ~sync3_r[3];

  // Address pins are caught while reset is held.
  logic [1:0] addr_cap_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_cap_r <= {sync2_r[4], sync2_r[0]};
    end
  end

  // Mode choice: a select fall after reset release means four-wire mode.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      spi_mode_o <= 1'b0;
    end else if (sel_fall) begin
      spi_mode_o <= 1'b1;
    end
  end

  wire logic din = spi_mode_o ? din_spi_s : sda_s;

  // Transfer state machine, advanced on sampling edges.
  ccp_state_t           state_r;
  logic [2:0]           cnt_r;
  logic [6:0]           shift_r;
  logic [REG_IDX_W-1:0] ptr_r;
  logic                 step_r;
  ccp_state_t           after_ack_r;

  wire logic [7:0] byte_in = {shift_r, din};
  wire logic       addr_ok = spi_mode_o ? (byte_in[7:1] == SPI_CHIP_ADDR)
                                        : (byte_in[7:1] == {I2C_ADDR_HI, addr_cap_r});

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r     <= CCP_IDLE;
      cnt_r       <= 3'h0;
      shift_r     <= 7'h00;
      ptr_r       <= '0;
      step_r      <= 1'b0;
      after_ack_r <= CCP_IDLE;
    end else if (spi_mode_o && sel_s) begin
      state_r <= CCP_IDLE;
    end else if (sel_fall || (!spi_mode_o && i2c_start)) begin
      state_r <= CCP_ADDR;
      cnt_r   <= 3'h0;
    end else if (!spi_mode_o && i2c_stop) begin
      state_r <= CCP_IDLE;
    end else if (sclk_rise) begin
      case (state_r)
        CCP_ADDR, CCP_PTR, CCP_WDATA, CCP_RDATA: begin
          shift_r <= byte_in[6:0];
          cnt_r   <= cnt_r + 3'h1;
          if (cnt_r == 3'h7) begin
            if (state_r == CCP_RDATA && step_r) begin
              ptr_r <= ptr_r + 7'h01;
            end
            case (state_r)
              CCP_ADDR: begin
                if (!addr_ok) begin
                  state_r <= CCP_IGNORE;
                end else if (spi_mode_o) begin
                  state_r <= byte_in[0] ? CCP_RDATA : CCP_PTR;
                end else begin
                  state_r     <= CCP_DEV_ACK;
                  after_ack_r <= byte_in[0] ? CCP_RDATA : CCP_PTR;
                end
              end
              CCP_PTR: begin
                ptr_r  <= byte_in[REG_IDX_W-1:0];
                step_r <= byte_in[PTR_STEP_BIT];
                state_r     <= spi_mode_o ? CCP_WDATA : CCP_DEV_ACK;
                after_ack_r <= CCP_WDATA;
              end
              CCP_WDATA: begin
                if (step_r) begin
                  ptr_r <= ptr_r + 7'h01;
                end
                state_r     <= spi_mode_o ? CCP_WDATA : CCP_DEV_ACK;
                after_ack_r <= CCP_WDATA;
              end
              default: begin
                state_r <= spi_mode_o ? CCP_RDATA : CCP_HOST_ACK;
              end
            endcase
          end
        end
        CCP_DEV_ACK: begin
          state_r <= after_ack_r;
          cnt_r   <= 3'h0;
        end
        CCP_HOST_ACK: begin
          state_r <= din ? CCP_IGNORE : CCP_RDATA;
          cnt_r   <= 3'h0;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Register write: the eighth bit of a data byte stores the byte at the pointer.
  wire logic wr_now = sclk_rise && state_r == CCP_WDATA && cnt_r == 3'h7
                      && !(spi_mode_o && sel_s) && !(!spi_mode_o && (i2c_start || i2c_stop));

  assign mem_if.we    = wr_now;
  assign mem_if.waddr = ptr_r;
  assign mem_if.wdata = byte_in;
  assign mem_if.raddr = ptr_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_wr_o      <= 1'b0;
      reg_wr_idx_o  <= '0;
      reg_wr_data_o <= 8'h00;
    end else begin
      reg_wr_o      <= wr_now;
      reg_wr_idx_o  <= ptr_r;
      reg_wr_data_o <= byte_in;
    end
  end

  // Output driver, updated on falling link clock edges.
  logic [7:0] tx_byte_r;
  logic       tx_bit;
  assign tx_bit = (cnt_r == 3'h0) ? mem_if.rdata[7] : tx_byte_r[3'h7 - cnt_r];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_serial_out_o    <= 1'b0;
      ctrl_serial_out_oe_o <= 1'b0;
      tx_byte_r            <= 8'h00;
    end else if ((spi_mode_o && sel_s) || (!spi_mode_o && (i2c_start || i2c_stop)) || state_r == CCP_IDLE) begin
      ctrl_serial_out_oe_o <= 1'b0;
    end else if (sclk_fall) begin
      if (cnt_r == 3'h0) begin
        tx_byte_r <= mem_if.rdata;
      end
      case (state_r)
        CCP_RDATA: begin
          ctrl_serial_out_o    <= spi_mode_o ? tx_bit : 1'b0;
          ctrl_serial_out_oe_o <= spi_mode_o | ~tx_bit;
        end
        CCP_DEV_ACK: begin
          ctrl_serial_out_o    <= 1'b0;
          ctrl_serial_out_oe_o <= 1'b1;
        end
        default: begin
          ctrl_serial_out_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Interrupts: per-source trigger select, sticky status, mask, pin style.
  logic [SRC_N-1:0] cond_d_r;
  logic [SRC_N-1:0] int_hit;
  logic             int_act;

  always_comb begin
    for (int i = 0; i < SRC_N; i++) begin
      case (int_trig_i[i])
        CCP_TRIG_RISE: int_hit[i] = int_cond_i[i] & ~cond_d_r[i];
        CCP_TRIG_FALL: int_hit[i] = ~int_cond_i[i] & cond_d_r[i];
        default:       int_hit[i] = int_cond_i[i];
      endcase
    end
  end

  assign int_act = |(int_status_o & ~int_mask_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cond_d_r     <= '0;
      int_status_o <= '0;
    end else begin
      cond_d_r     <= int_cond_i;
      int_status_o <= int_hit | (int_status_o & ~int_clear_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_o    <= 1'b1;
      int_oe_o <= 1'b0;
    end else begin
      case (int_pin_mode_i)
        CCP_INT_HIGH_PP: begin
          int_o    <= int_act;
          int_oe_o <= 1'b1;
        end
        CCP_INT_LOW_OD: begin
          int_o    <= 1'b0;
          int_oe_o <= int_act;
        end
        default: begin
          int_o    <= ~int_act;
          int_oe_o <= 1'b1;
        end
      endcase
    end
  end

  // Power-down bit mirrors writes to the power control register.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_down_o <= PWR_CTRL_RST[PDN_BIT];
    end else if (wr_now && ptr_r == PWR_CTRL_IDX) begin
      power_down_o <= byte_in[PDN_BIT];
    end
  end

  // Mute timer started by reset release.
  logic [MUTE_CNT_W-1:0] mute_cnt_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mute_cnt_r <= MUTE_CNT_W'(MUTE_LEN);
    end else if (mute_cnt_r != '0) begin
      mute_cnt_r <= mute_cnt_r - MUTE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mute_o         <= 1'b1;
      audio_out_en_o <= 1'b0;
    end else begin
      mute_o         <= (mute_cnt_r != '0) | power_down_o;
      audio_out_en_o <= (mute_cnt_r == '0) & ~power_down_o & (~pll_selected_i | pll_locked_i);
    end
  end

endmodule

// ---- verif/ccp_checker.sv ----
// Concurrent checks on the control port outputs.
// Assumes it is bound into ccp_top and sees only its ports.
module ccp_checker
  import ccp_pkg::*;
#(
  parameter longint unsigned MUTE_LEN = MUTE_CYCLES
) (
  // Clock and reset.
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  // Link pins.
  input wire logic                  addr0_or_select_pin_i,
  input wire logic                  ctrl_serial_out_o,
  input wire logic                  ctrl_serial_out_oe_o,
  // Status and control.
  input wire logic                  reg_wr_o,
  input wire logic [REG_IDX_W-1:0]  reg_wr_idx_o,
  input wire logic [7:0]            reg_wr_data_o,
  input wire logic                  spi_mode_o,
  input wire ccp_pkg::ccp_int_pin_t int_pin_mode_i,
  input wire logic                  int_o,
  input wire logic                  int_oe_o,
  input wire logic                  pll_selected_i,
  input wire logic                  pll_locked_i,
  input wire logic                  power_down_o,
  input wire logic                  mute_o,
  input wire logic                  audio_out_en_o
);
  timeunit 1ns;
  timeprecision 100ps;

  longint unsigned run_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Counts cycles since reset release, saturating at the mute length.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_r <= '0;
    end else if (run_r < MUTE_LEN) begin
      run_r <= run_r + 64'd1;
    end
  end

  property p_rst_quiet;
    disable iff (1'b0) !rst_n_i |=> !ctrl_serial_out_oe_o && !int_oe_o && !reg_wr_o && power_down_o && mute_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active in reset");
  property p_mute_hold;
    run_r + 64'd2 < MUTE_LEN |-> mute_o;
  endproperty
  a_mute_hold: assert property (p_mute_hold) else $error("unmuted too early");
  property p_pll_gate;
    (pll_selected_i && !pll_locked_i) [*3] |-> !audio_out_en_o;
  endproperty
  a_pll_gate: assert property (p_pll_gate) else $error("audio on before lock");
  property p_pdn_gate;
    power_down_o [*2] |-> !audio_out_en_o;
  endproperty
  a_pdn_gate: assert property (p_pdn_gate) else $error("audio on in power down");
  property p_pdn_clr;
    reg_wr_o && reg_wr_idx_o == PWR_CTRL_IDX && !reg_wr_data_o[PDN_BIT] |-> ##[0:2] !power_down_o;
  endproperty
  a_pdn_clr: assert property (p_pdn_clr) else $error("power down not left");
  property p_mode_sel;
    $rose(spi_mode_o) |-> !$past(addr0_or_select_pin_i, 2);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode change without select");
  property p_sel_idle;
    (spi_mode_o && addr0_or_select_pin_i) [*6] |-> !ctrl_serial_out_oe_o;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("output driven while deselected");
  property p_od_ack;
    !spi_mode_o && ctrl_serial_out_oe_o |-> !ctrl_serial_out_o;
  endproperty
  a_od_ack: assert property (p_od_ack) else $error("data line driven high");
  property p_int_od;
    (int_pin_mode_i == CCP_INT_LOW_OD) [*3] ##0 int_oe_o |-> !int_o;
  endproperty
  a_int_od: assert property (p_int_od) else $error("open drain pin driven high");
  property p_wr_pulse;
    reg_wr_o |=> !reg_wr_o;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");

  c_spi: cover property ($rose(spi_mode_o));
  c_read: cover property (spi_mode_o && ctrl_serial_out_oe_o);
  c_int: cover property (int_oe_o && int_o && int_pin_mode_i == CCP_INT_HIGH_PP);
endmodule

bind ccp_top ccp_checker #(.MUTE_LEN(MUTE_LEN)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr0_or_select_pin_i(addr0_or_select_pin_i),
  .ctrl_serial_out_o(ctrl_serial_out_o), .ctrl_serial_out_oe_o(ctrl_serial_out_oe_o),
  .reg_wr_o(reg_wr_o), .reg_wr_idx_o(reg_wr_idx_o), .reg_wr_data_o(reg_wr_data_o),
  .spi_mode_o(spi_mode_o), .int_pin_mode_i(int_pin_mode_i), .int_o(int_o), .int_oe_o(int_oe_o),
  .pll_selected_i(pll_selected_i), .pll_locked_i(pll_locked_i), .power_down_o(power_down_o),
  .mute_o(mute_o), .audio_out_en_o(audio_out_en_o)
);

// ---- verif/ccp_host_model.sv ----
// Host master driving the link pins in either wire mode.
// Assumes the data line is resolved outside and returned on line_i.
module ccp_host_model (
  output logic      sclk_o,
  output logic      sel_o,
  output logic      sdi_o,
  output logic      sda_o,
  input  wire logic line_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pins stay static while idle.
  initial begin
    sclk_o = 1'b1;
    sel_o  = 1'b1;
    sdi_o  = 1'b1;
    sda_o  = 1'b1;
  end

  // One 48 ns link bit; data moves only while the clock is low.
  task automatic xbit(input logic b, output logic r);
    sclk_o = 1'b0;
    #8;
    sdi_o = b;
    sda_o = b;
    #16;
    sclk_o = 1'b1;
    #24;
    r = line_i;
  endtask

  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) xbit(b[i], r[i]);
  endtask

  task automatic open_f(input logic spi);
    if (spi) sel_o = 1'b0;
    else sda_o = 1'b0;
    #24;
  endtask

  // Ends a frame right after its last byte, which also aborts a pointer-only write.
  task automatic close_f(input logic spi);
    #8;
    if (spi) begin
      sel_o = 1'b1;
    end else begin
      sclk_o = 1'b0;
      #8 sda_o = 1'b0;
      #16 sclk_o = 1'b1;
      #24 sda_o = 1'b1;
    end
    #96;
  endtask
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the control port in both wire modes.
// Assumes the host model drives the link and the bench drives the rest.
module testbench
  import ccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam longint unsigned ML = 50;

  logic         clk_i, rst_n_i, sel, sclk, sdi, sda, ahi, line, sdo, sdo_oe, oe_hit;
  logic         reg_wr, spi_mode, int_o, int_oe, power_down_bit, mute, aud, pll_sel, pll_lk;
  logic [6:0]   wr_idx;
  logic [7:0]   wr_data, cond, mask, clr, st, d0, d1, d2;
  ccp_trig_t    trig [8];
  ccp_int_pin_t pmode;
  logic [14:0]  wq[$];
  logic [7:0]   rq[$];
  logic [31:0]  seed;
  int           fails, n_tests;

  always #2.5 clk_i = ~clk_i;
  // Open-drain data line with pull-up; the device pulls it low whenever it drives a 0, in either wire mode.
  assign line = sdo_oe ? (sdo & sda) : sda;

  ccp_top #(.MUTE_LEN(ML), .SRC_N(8)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr0_or_select_pin_i(sel), .addr_sel_high_bit_i(ahi),
    .ctrl_bit_clock_i(sclk), .ctrl_serial_in_i(sdi), .ctrl_serial_out_i(line),
    .ctrl_serial_out_o(sdo), .ctrl_serial_out_oe_o(sdo_oe), .reg_wr_o(reg_wr),
    .reg_wr_idx_o(wr_idx), .reg_wr_data_o(wr_data), .spi_mode_o(spi_mode), .int_cond_i(cond),
    .int_mask_i(mask), .int_trig_i(trig), .int_pin_mode_i(pmode), .int_clear_i(clr),
    .int_status_o(st), .int_o(int_o), .int_oe_o(int_oe), .pll_selected_i(pll_sel),
    .pll_locked_i(pll_lk), .power_down_o(power_down_bit), .mute_o(mute), .audio_out_en_o(aud)
  );

  ccp_host_model host (.sclk_o(sclk), .sel_o(sel), .sdi_o(sdi), .sda_o(sda), .line_i(line));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Sends bytes, then reads nrd bytes; in two-wire mode each byte carries an acknowledge.
  task automatic frame(input logic spi, input logic [7:0] tx[$], input int nrd, input logic nak);
    logic       a;
    logic [7:0] r;
    host.open_f(spi);
    foreach (tx[i]) begin
      host.xbyte(tx[i], r);
      if (!spi) host.xbit(1'b1, a);
      if (!spi) check("ack", 16'(a), 16'(nak));
    end
    for (int i = 0; i < nrd; i++) begin
      host.xbyte(8'hFF, r);
      rq.push_back(r);
      if (!spi) host.xbit(i == nrd - 1, a);
    end
    host.close_f(spi);
  endtask

  task automatic rd_chk(input logic [7:0] e);
    check("rd", 16'(rq.pop_front()), 16'(e));
  endtask

  // Every register write is matched against the oldest expected write.
  always @(posedge clk_i) begin
    if (rst_n_i && reg_wr === 1'b1) begin
      if (wq.size() == 0) check("wr_extra", 16'(wr_idx), 16'hFFFF);
      else check("wr", 16'({wr_idx, wr_data}), 16'(wq.pop_front()));
    end
    if (sdo_oe === 1'b1) oe_hit <= 1'b1;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end

  initial begin
    {clk_i, rst_n_i, ahi, clr, pll_sel, pll_lk, oe_hit, fails, n_tests} = '0;
    cond = 8'h02;
    mask = 8'hF8;
    pmode = CCP_INT_LOW_PP;
    foreach (trig[i]) trig[i] = CCP_TRIG_LEVEL;
    trig[0] = CCP_TRIG_RISE;
    trig[1] = CCP_TRIG_FALL;
    seed = lfsr(32'h1B77);
    d0 = seed[7:0];
    seed = lfsr(seed);
    d1 = seed[7:0];
    seed = lfsr(seed);
    d2 = seed[7:0];
    repeat (15) @(posedge clk_i);
    check("rst", 16'({power_down_bit, mute, aud, sdo_oe, int_oe, st}), 16'h1800);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    ahi <= 1'b1;
    repeat (10) @(posedge clk_i);
    check("mute", 16'(mute), 16'h0001);
    wq.push_back({7'h05, d0});
    wq.push_back({7'h06, d1});
    frame(0, '{{I2C_ADDR_HI, 2'b01, 1'b0}, 8'h85, d0, d1}, 0, 0);
    frame(0, '{{I2C_ADDR_HI, 2'b11, 1'b0}}, 0, 1);
    frame(0, '{{I2C_ADDR_HI, 2'b01, 1'b0}, 8'h05}, 0, 0);
    frame(0, '{{I2C_ADDR_HI, 2'b01, 1'b1}}, 2, 0);
    rd_chk(d0);
    rd_chk(d0);
    check("mode", 16'(spi_mode), 16'h0000);
    // Two-wire acknowledges drove the pin; start the four-wire watch clean.
    oe_hit = 1'b0;
    wq.push_back({PWR_CTRL_IDX, 8'h00});
    wq.push_back({PWR_CTRL_IDX + 7'h01, d2});
    frame(1, '{{SPI_CHIP_ADDR, 1'b0}, {1'b1, PWR_CTRL_IDX}, 8'h00, d2}, 0, 0);
    check("mode", 16'(spi_mode), 16'h0001);
    check("pdn", 16'(power_down_bit), 16'h0000);
    frame(1, '{{SPI_CHIP_ADDR, 1'b0}, {1'b1, PWR_CTRL_IDX + 7'h01}}, 0, 0);
    check("wr_oe", 16'(oe_hit), 16'h0000);
    frame(1, '{{SPI_CHIP_ADDR, 1'b1}}, 2, 0);
    rd_chk(d2);
    rd_chk(8'h00);
    check("rd_oe", 16'(oe_hit), 16'h0001);
    oe_hit = 1'b0;
    frame(1, '{{SPI_CHIP_ADDR ^ 7'h01, 1'b0}, 8'h82, 8'h55}, 0, 0);
    frame(1, '{{SPI_CHIP_ADDR ^ 7'h01, 1'b1}}, 1, 0);
    rd_chk(8'hFF);
    check("bad_oe", 16'(oe_hit), 16'h0000);
    pll_sel <= 1'b1;
    repeat (5) @(posedge clk_i);
    check("pll", 16'({mute, aud}), 16'h0000);
    pll_lk <= 1'b1;
    repeat (5) @(posedge clk_i);
    check("aud", 16'(aud), 16'h0001);
    cond <= 8'h0A;
    repeat (5) @(posedge clk_i);
    check("masked", 16'({int_o, int_oe, st[2:0]}), 16'h0018);
    cond <= 8'h0D;
    repeat (5) @(posedge clk_i);
    check("trig", 16'({int_o, int_oe, st[2:0]}), 16'h000F);
    pmode <= CCP_INT_HIGH_PP;
    repeat (5) @(posedge clk_i);
    check("pp_hi", 16'({int_o, int_oe}), 16'h0003);
    pmode <= CCP_INT_LOW_OD;
    repeat (5) @(posedge clk_i);
    check("od", 16'({int_o, int_oe}), 16'h0001);
    cond <= 8'h09;
    clr <= 8'h07;
    @(posedge clk_i);
    clr <= 8'h00;
    repeat (5) @(posedge clk_i);
    check("clr", 16'({int_oe, st[2:0]}), 16'h0000);
    check("wq", 16'(wq.size()), 16'h0000);
    close_out();
  end
endmodule
